// ---- logic/amp_regs_pkg.sv ----
// Purpose: Shared constants and types for the amplifier status register bank
// Assumes: Plain register port, 9-bit byte address, 8-bit data
// Notes:   Times are in their own unit; cycle counts derive in the top module
package amp_regs_pkg;

	localparam int ADDR_W = 9;

	localparam logic [8:0] POWER_MODE_STATUS_ADDR      = 9'h0bd;
	localparam logic [8:0] MOD_INDEX_CH0_ADDR          = 9'h0be;
	localparam logic [8:0] MOD_INDEX_CH1_ADDR          = 9'h0bf;
	localparam logic [8:0] ERROR_TRIGGER_CLEAR_ADDR    = 9'h109;
	localparam logic [8:0] SYSTEM_ERROR_LIVE_ADDR      = 9'h11a;
	localparam logic [8:0] CHANNEL0_ERROR_LATCHED_ADDR = 9'h11c;
	localparam logic [8:0] CHANNEL1_ERROR_LATCHED_ADDR = 9'h11d;
	localparam logic [8:0] SYSTEM_ERROR_LATCHED_ADDR   = 9'h11e;
	localparam logic [8:0] UNMUTE_DELAY_SELECT_ADDR    = 9'h142;
	localparam logic [8:0] MODULATOR_PHASE_DELAY_ADDR  = 9'h15f;
	localparam logic [8:0] SYNC_CONTROL_ADDR           = 9'h027;

	localparam int CLEAR_BIT    = 1;
	localparam int SYNC_IN_BIT  = 0;
	localparam int SYNC_OUT_BIT = 1;
	localparam int FAST_BIT     = 2;

	localparam logic [7:0] SYS_ERR_MASK = 8'hf7;
	localparam logic [4:0] CH_ERR_MASK  = 5'h0d;

	localparam logic [3:0] UNMUTE_RST   = 4'h3;
	localparam logic [3:0] UNMUTE_SHORT = 4'hd;
	localparam logic [6:0] PHASE_RST    = 7'h00;
	localparam logic [2:0] SYNC_RST     = 3'h4;

	localparam int UNMUTE_LONG_MS  = 300;
	localparam int UNMUTE_SHORT_MS = 30;
	localparam int CLK_KHZ         = 125000;

	localparam logic [13:0] SYNC_SLOW_DIV = 14'h3000;
	localparam logic [13:0] SYNC_FAST_DIV = 14'h000c;
	localparam logic [2:0]  SYNC_LOW_CYC  = 3'h4;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	typedef struct packed {
		logic [2:0] power_profile_chan0;
		logic [2:0] power_profile_chan1;
		logic [7:0] mod_index_chan0;
		logic [7:0] mod_index_chan1;
		logic [7:0] system_error_bits;
		logic [4:0] chan0_error_bits;
		logic [4:0] chan1_error_bits;
	} status_in_t;

	typedef enum logic [1:0] {MUTED, COUNTING, PLAYING} mute_state_t;

endpackage : amp_regs_pkg

// ---- logic/amp_status_error_regs.sv ----
// Purpose: Status, error and timing-control registers of the amplifier
// Assumes: Status and error inputs come from logic on clk; pins do not
// Notes:   Read data stands for exactly one cycle after the read strobe
//
// Function
// - Status register shows channel 0 power mode in 2:0, channel 1 in 5:3
// - Each channel shows an eight-bit modulation index, 0 to 255 linear
// - Writing one to bit 1 clears the error trigger; zero leaves it
// - Live system error vector shows current conditions, bit 3 reserved
// - Accumulated system error vector records every condition seen
// - Channel 0 accumulated vector: DC, flying cap, over-current bits
// - Channel 1 accumulated vector laid out as channel 0
// - Four-bit code selects delay from mute release to playback
// - Seven-bit phase delays PWM in 22.5 degree steps, 16 wraps to 0
// - Phase offset applies while PWM synchronisation is active
// - Sync pin as input or open-drain output; slow or fast rate
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module amp_status_error_regs #(
	parameter int UNMUTE_LONG_CYC  = amp_regs_pkg::UNMUTE_LONG_MS *
		amp_regs_pkg::CLK_KHZ,
	parameter int UNMUTE_SHORT_CYC = amp_regs_pkg::UNMUTE_SHORT_MS *
		amp_regs_pkg::CLK_KHZ
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire amp_regs_pkg::bus_req_t   bus_req,
	output logic [7:0]                    rd_data,
	input  wire amp_regs_pkg::status_in_t status_in,
	input  wire logic                     mute_input_pin,
	input  wire logic                     fs_tick,
	input  wire logic                     pwm_slot_tick,
	input  wire logic                     clip_sync_pin_in,
	output logic                          clip_sync_pin_out,
	output logic                          clip_sync_pin_oe,
	output logic                          audio_play,
	output logic                          pwm_start,
	output logic                          error_trigger
);
	import amp_regs_pkg::*;

	logic [7:0]  rd_data_q;
	logic [5:0]  power_mode_q;
	logic [7:0]  mod0_q;
	logic [7:0]  mod1_q;
	logic [7:0]  sys_live_q;
	logic [7:0]  sys_acc_q;
	logic [7:0]  sys_acc_d;
	logic [4:0]  ch0_acc_q;
	logic [4:0]  ch0_acc_d;
	logic [4:0]  ch1_acc_q;
	logic [4:0]  ch1_acc_d;
	logic        trig_q;
	logic [3:0]  unmute_sel_q;
	logic [6:0]  phase_q;
	logic [2:0]  sync_ctl_q;
	logic        clr_wr;
	logic        mute_meta_q;
	logic        mute_sync_q;
	mute_state_t mute_state_q;
	logic [25:0] unmute_cnt_q;
	logic [25:0] unmute_last;
	logic        play_q;
	logic [13:0] sync_div_q;
	logic [13:0] sync_div_last;
	logic        sync_out_next;
	logic [2:0]  sync_low_q;
	logic        sync_oe_q;
	logic        sync_meta_q;
	logic        sync_in_q;
	logic        sync_prev_q;
	logic        sync_fall;
	logic        sync_active;
	logic [3:0]  slot_q;
	logic [3:0]  phase_eff;
	logic        start_q;

	assign rd_data           = rd_data_q;
	assign clip_sync_pin_out = 1'b0;
	assign clip_sync_pin_oe  = sync_oe_q;
	assign audio_play        = play_q;
	assign pwm_start         = start_q;
	assign error_trigger     = trig_q;

	assign clr_wr = bus_req.wr &&
		bus_req.addr == ERROR_TRIGGER_CLEAR_ADDR &&
		bus_req.wdata[CLEAR_BIT];

	// Status snapshot, refreshed every cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_mode_q <= 6'h00;
			mod0_q       <= 8'h00;
			mod1_q       <= 8'h00;
			sys_live_q   <= 8'h00;
		end else begin
			power_mode_q <= {status_in.power_profile_chan1,
				status_in.power_profile_chan0};
			mod0_q       <= status_in.mod_index_chan0;
			mod1_q       <= status_in.mod_index_chan1;
			sys_live_q   <= status_in.system_error_bits & SYS_ERR_MASK;
		end
	end

	// A new error wins over a clear in the same cycle
	always_comb begin
		sys_acc_d = (clr_wr ? 8'h00 : sys_acc_q) |
			(status_in.system_error_bits & SYS_ERR_MASK);
		ch0_acc_d = (clr_wr ? 5'h00 : ch0_acc_q) |
			(status_in.chan0_error_bits & CH_ERR_MASK);
		ch1_acc_d = (clr_wr ? 5'h00 : ch1_acc_q) |
			(status_in.chan1_error_bits & CH_ERR_MASK);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sys_acc_q <= 8'h00;
			ch0_acc_q <= 5'h00;
			ch1_acc_q <= 5'h00;
			trig_q    <= 1'b0;
		end else begin
			sys_acc_q <= sys_acc_d;
			ch0_acc_q <= ch0_acc_d;
			ch1_acc_q <= ch1_acc_d;
			trig_q    <= |{sys_acc_d, ch0_acc_d, ch1_acc_d};
		end
	end

	// Writable control registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			unmute_sel_q <= UNMUTE_RST;
			phase_q      <= PHASE_RST;
			sync_ctl_q   <= SYNC_RST;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				UNMUTE_DELAY_SELECT_ADDR: begin
					unmute_sel_q <= bus_req.wdata[3:0];
				end
				MODULATOR_PHASE_DELAY_ADDR: begin
					phase_q <= bus_req.wdata[6:0];
				end
				SYNC_CONTROL_ADDR: begin
					sync_ctl_q <= bus_req.wdata[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read port; unmapped addresses and the clear register read zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_data_q <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				POWER_MODE_STATUS_ADDR: begin
					rd_data_q <= {2'b00, power_mode_q};
				end
				MOD_INDEX_CH0_ADDR: begin
					rd_data_q <= mod0_q;
				end
				MOD_INDEX_CH1_ADDR: begin
					rd_data_q <= mod1_q;
				end
				SYSTEM_ERROR_LIVE_ADDR: begin
					rd_data_q <= sys_live_q;
				end
				CHANNEL0_ERROR_LATCHED_ADDR: begin
					rd_data_q <= {3'b000, ch0_acc_q};
				end
				CHANNEL1_ERROR_LATCHED_ADDR: begin
					rd_data_q <= {3'b000, ch1_acc_q};
				end
				SYSTEM_ERROR_LATCHED_ADDR: begin
					rd_data_q <= sys_acc_q;
				end
				UNMUTE_DELAY_SELECT_ADDR: begin
					rd_data_q <= {4'h0, unmute_sel_q};
				end
				MODULATOR_PHASE_DELAY_ADDR: begin
					rd_data_q <= {1'b0, phase_q};
				end
				SYNC_CONTROL_ADDR: begin
					rd_data_q <= {5'h00, sync_ctl_q};
				end
				default: begin
					rd_data_q <= 8'h00;
				end
			endcase
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	// Mute pin synchroniser
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mute_meta_q <= 1'b0;
			mute_sync_q <= 1'b0;
		end else begin
			mute_meta_q <= mute_input_pin;
			mute_sync_q <= mute_meta_q;
		end
	end

	// Only the short code selects the short delay; all others the long one
	assign unmute_last = (unmute_sel_q == UNMUTE_SHORT) ?
		26'(UNMUTE_SHORT_CYC - 1) : 26'(UNMUTE_LONG_CYC - 1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mute_state_q <= MUTED;
			unmute_cnt_q <= 26'h0000000;
			play_q       <= 1'b0;
		end else if (!mute_sync_q) begin
			mute_state_q <= MUTED;
			unmute_cnt_q <= 26'h0000000;
			play_q       <= 1'b0;
		end else begin
			case (mute_state_q)
				MUTED: begin
					mute_state_q <= COUNTING;
					unmute_cnt_q <= 26'h0000000;
				end
				COUNTING: begin
					if (unmute_cnt_q >= unmute_last) begin
						mute_state_q <= PLAYING;
						play_q       <= 1'b1;
					end else begin
						unmute_cnt_q <= unmute_cnt_q + 26'h0000001;
					end
				end
				PLAYING: begin
					play_q <= 1'b1;
				end
				default: begin
					mute_state_q <= MUTED;
					play_q       <= 1'b0;
				end
			endcase
		end
	end

	// Sync output: open-drain low pulse every fs/12288 or fs/12
	assign sync_div_last = (sync_ctl_q[FAST_BIT] ? SYNC_FAST_DIV :
		SYNC_SLOW_DIV) - 14'h0001;
	assign sync_out_next =
		(bus_req.wr && bus_req.addr == SYNC_CONTROL_ADDR) ?
		bus_req.wdata[SYNC_OUT_BIT] : sync_ctl_q[SYNC_OUT_BIT];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_div_q <= 14'h0000;
			sync_low_q <= 3'h0;
			sync_oe_q  <= 1'b0;
		end else begin
			if (fs_tick) begin
				if (sync_div_q >= sync_div_last) begin
					sync_div_q <= 14'h0000;
				end else begin
					sync_div_q <= sync_div_q + 14'h0001;
				end
			end
			if (sync_out_next && fs_tick && sync_div_q >= sync_div_last) begin
				sync_low_q <= SYNC_LOW_CYC;
				sync_oe_q  <= 1'b1;
			end else if (sync_low_q > 3'h1 && sync_out_next) begin
				sync_low_q <= sync_low_q - 3'h1;
			end else begin
				sync_low_q <= 3'h0;
				sync_oe_q  <= 1'b0;
			end
		end
	end

	// Sync input synchroniser and falling-edge detect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_meta_q <= 1'b1;
			sync_in_q   <= 1'b1;
			sync_prev_q <= 1'b1;
		end else begin
			sync_meta_q <= clip_sync_pin_in;
			sync_in_q   <= sync_meta_q;
			sync_prev_q <= sync_in_q;
		end
	end

	assign sync_fall   = sync_ctl_q[SYNC_IN_BIT] && sync_prev_q && !sync_in_q;
	assign sync_active = sync_ctl_q[SYNC_IN_BIT] || sync_ctl_q[SYNC_OUT_BIT];
	// Code 16 wraps to the same slot as code 0
	assign phase_eff   = sync_active ? phase_q[3:0] : 4'h0;

	// PWM slot counter, 16 slots of 22.5 degrees; realigned by sync input
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_q  <= 4'h0;
			start_q <= 1'b0;
		end else begin
			if (sync_fall) begin
				slot_q <= 4'h0;
			end else if (pwm_slot_tick) begin
				slot_q <= slot_q + 4'h1;
			end
			start_q <= pwm_slot_tick && !sync_fall &&
				slot_q == phase_eff;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	pm_readback_a: assert property (
		bus_req.rd && bus_req.addr == POWER_MODE_STATUS_ADDR |=>
		rd_data_q[5:0] == $past({status_in.power_profile_chan1,
			status_in.power_profile_chan0}, 2))
		else $error("power mode readback wrong");

	mod_readback_a: assert property (
		bus_req.rd && bus_req.addr == MOD_INDEX_CH1_ADDR |=>
		rd_data_q == $past(status_in.mod_index_chan1, 2))
		else $error("modulation index readback wrong");

	trig_clear_a: assert property (
		clr_wr && status_in.system_error_bits == 8'h00 &&
		status_in.chan0_error_bits == 5'h00 &&
		status_in.chan1_error_bits == 5'h00 |=> !trig_q)
		else $error("error trigger not cleared");

	trig_hold_a: assert property (
		trig_q && !clr_wr |=> trig_q)
		else $error("error trigger dropped without clear");

	live_reserved_a: assert property (
		bus_req.rd && bus_req.addr == SYSTEM_ERROR_LIVE_ADDR |=>
		rd_data_q[3] == 1'b0 &&
		rd_data_q == ($past(status_in.system_error_bits, 2) & SYS_ERR_MASK))
		else $error("live error vector wrong");

	sys_capture_a: assert property (
		##1 (sys_acc_q & $past(status_in.system_error_bits & SYS_ERR_MASK))
		== $past(status_in.system_error_bits & SYS_ERR_MASK))
		else $error("system error not recorded");

	sys_sticky_a: assert property (
		!clr_wr |=> (sys_acc_q & $past(sys_acc_q)) == $past(sys_acc_q))
		else $error("accumulated error lost");

	ch_layout_a: assert property (
		(ch0_acc_q & ~CH_ERR_MASK) == 5'h00 &&
		(ch1_acc_q & ~CH_ERR_MASK) == 5'h00)
		else $error("reserved channel error bit set");

	ch1_capture_a: assert property (
		status_in.chan1_error_bits[0] |=> ch1_acc_q[0])
		else $error("channel 1 over-current not recorded");

	mute_hold_a: assert property (
		!mute_sync_q |=> !play_q)
		else $error("playback while muted");

	phase_slot_a: assert property (
		start_q |-> $past(slot_q) == $past(phase_eff))
		else $error("PWM start at wrong phase slot");

	sync_drive_a: assert property (
		clip_sync_pin_oe |-> sync_ctl_q[SYNC_OUT_BIT] && !clip_sync_pin_out)
		else $error("sync pin driven while output disabled");
endmodule : amp_status_error_regs

// ---- verification/sync_peer.sv ----
// Purpose: Second device sharing the open-drain clip/sync wire
// Assumes: The wire has a pull-up; either party may pull it low
// Notes:   Pulls the wire low while pull is high
`timescale 1ns/1ns
module sync_peer (
	input  wire logic dut_oe,
	input  wire logic dut_out,
	input  wire logic pull,
	output logic      wire_level
);
	// Pull-up level unless a party drives low
	assign wire_level = !((dut_oe && !dut_out) || pull);
endmodule : sync_peer

// ---- verification/amp_status_error_regs_bench.sv ----
// Purpose: Self-checking bench for the amplifier status registers
// Assumes: Short unmute counts; fs and slot ticks every second cycle
// Notes:   Read results are queued and compared by a watcher process
`timescale 1ns/1ns
module amp_status_error_regs_bench;
	import amp_regs_pkg::*;
	localparam int SHORT_CYC = 10;
	localparam int LONG_CYC  = 40;
	logic        clk      = 1'b0;
	logic        sys_rst  = 1'b1;
	bus_req_t    bus_req  = '0;
	status_in_t  status_in = '0;
	status_in_t  st;
	logic [7:0]  rd_data;
	logic        mute_pin = 1'b0;
	logic        tick     = 1'b0;
	logic        pull     = 1'b0;
	logic        pend     = 1'b0;
	logic        sync_level;
	logic        pin_out;
	logic        pin_oe;
	logic        audio_play;
	logic        pwm_start;
	logic        err_trig;
	logic [7:0]  exp_q[$];
	logic [7:0]  accs     = '0;
	logic [15:0] seed     = 16'h8290;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc      = 0;
	int          n;
	int          a;
	int          b;
	int          c;

	always #4 clk = ~clk;

	amp_status_error_regs #(
		.UNMUTE_LONG_CYC (LONG_CYC),
		.UNMUTE_SHORT_CYC(SHORT_CYC)
	) dut (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.bus_req          (bus_req),
		.rd_data          (rd_data),
		.status_in        (status_in),
		.mute_input_pin   (mute_pin),
		.fs_tick          (tick),
		.pwm_slot_tick    (tick),
		.clip_sync_pin_in (sync_level),
		.clip_sync_pin_out(pin_out),
		.clip_sync_pin_oe (pin_oe),
		.audio_play       (audio_play),
		.pwm_start        (pwm_start),
		.error_trigger    (err_trig)
	);

	sync_peer peer (
		.dut_oe    (pin_oe),
		.dut_out   (pin_out),
		.pull      (pull),
		.wire_level(sync_level)
	);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic wait_cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : wait_cyc

	task automatic wr(input logic [8:0] ad, input logic [7:0] d);
		@(posedge clk);
		bus_req.addr <= ad;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] ad, input logic [7:0] e);
		@(posedge clk);
		bus_req.addr <= ad;
		bus_req.rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		bus_req.rd <= 1'b0;
	endtask : rd

	task automatic mute_test(input int k);
		@(posedge clk);
		mute_pin <= 1'b1;
		wait_cyc(k - 2);
		check(audio_play, 1'b0);
		wait_cyc(10);
		check(audio_play, 1'b1);
		mute_pin <= 1'b0;
		wait_cyc(6);
		check(audio_play, 1'b0);
	endtask : mute_test

	// Time from pulling the sync wire low to the next PWM start
	task automatic meas(input logic [7:0] ph, output int t);
		wr(MODULATOR_PHASE_DELAY_ADDR, ph);
		wait_cyc(40);
		while (cyc[0] !== 1'b0)
			@(posedge clk);
		pull <= 1'b1;
		wait_cyc(4);
		for (t = 4; t < 60 && pwm_start !== 1'b1; t++)
			@(posedge clk);
		pull <= 1'b0;
		check(pin_oe, 1'b0);
	endtask : meas

	always @(posedge clk) begin
		cyc <= cyc + 1;
		tick <= ~tick;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	always @(posedge clk) begin
		if (pend)
			check(rd_data, exp_q.pop_front());
		pend <= bus_req.rd;
	end

	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(UNMUTE_DELAY_SELECT_ADDR, 8'h03);
		rd(MODULATOR_PHASE_DELAY_ADDR, 8'h00);
		rd(SYNC_CONTROL_ADDR, 8'h04);
		rd(SYSTEM_ERROR_LATCHED_ADDR, 8'h00);
		rd(9'h000, 8'h00);
		for (n = 0; n < 4; n++) begin
			seed = lfsr(seed);
			st = '0;
			st.power_profile_chan0 = seed[2:0];
			st.power_profile_chan1 = seed[5:3];
			st.mod_index_chan0 = (n == 0) ? 8'hff : seed[7:0];
			st.mod_index_chan1 = (n == 1) ? 8'h00 : seed[15:8];
			st.system_error_bits = seed[15:8] & 8'hf7;
			accs = accs | st.system_error_bits;
			@(posedge clk);
			status_in <= st;
			wait_cyc(1);
			rd(POWER_MODE_STATUS_ADDR, {2'b00, st.power_profile_chan1,
				st.power_profile_chan0});
			rd(MOD_INDEX_CH0_ADDR, st.mod_index_chan0);
			rd(MOD_INDEX_CH1_ADDR, st.mod_index_chan1);
			rd(SYSTEM_ERROR_LIVE_ADDR, st.system_error_bits);
		end
		@(posedge clk);
		status_in <= '0;
		wait_cyc(4);
		wr(POWER_MODE_STATUS_ADDR, 8'hff);
		rd(POWER_MODE_STATUS_ADDR, 8'h00);
		rd(SYSTEM_ERROR_LATCHED_ADDR, accs);
		check(err_trig, accs != 8'h00);
		wr(ERROR_TRIGGER_CLEAR_ADDR, 8'hfd);
		rd(SYSTEM_ERROR_LATCHED_ADDR, accs);
		wr(ERROR_TRIGGER_CLEAR_ADDR, 8'h02);
		rd(SYSTEM_ERROR_LATCHED_ADDR, 8'h00);
		rd(ERROR_TRIGGER_CLEAR_ADDR, 8'h00);
		check(err_trig, 1'b0);
		@(posedge clk);
		st = '0;
		st.chan0_error_bits = 5'h1f;
		st.chan1_error_bits = 5'h17;
		status_in <= st;
		@(posedge clk);
		status_in <= '0;
		wait_cyc(5);
		check(err_trig, 1'b1);
		rd(CHANNEL0_ERROR_LATCHED_ADDR, 8'h0d);
		rd(CHANNEL1_ERROR_LATCHED_ADDR, 8'h05);
		wr(ERROR_TRIGGER_CLEAR_ADDR, 8'h02);
		rd(CHANNEL0_ERROR_LATCHED_ADDR, 8'h00);
		rd(CHANNEL1_ERROR_LATCHED_ADDR, 8'h00);
		wr(UNMUTE_DELAY_SELECT_ADDR, {4'h0, UNMUTE_SHORT});
		rd(UNMUTE_DELAY_SELECT_ADDR, {4'h0, UNMUTE_SHORT});
		mute_test(SHORT_CYC);
		wr(UNMUTE_DELAY_SELECT_ADDR, {4'h0, UNMUTE_RST});
		mute_test(LONG_CYC);
		wr(SYNC_CONTROL_ADDR, 8'h06);
		for (n = 0; n < 60 && pin_oe !== 1'b1; n++)
			@(posedge clk);
		a = cyc;
		check(sync_level, 1'b0);
		for (n = 0; n < 10 && pin_oe === 1'b1; n++)
			@(posedge clk);
		check(n, SYNC_LOW_CYC);
		for (n = 0; n < 60 && pin_oe !== 1'b1; n++)
			@(posedge clk);
		check(cyc - a, 24);
		wr(SYNC_CONTROL_ADDR, 8'h04);
		wait_cyc(1);
		check(pin_oe, 1'b0);
		wr(SYNC_CONTROL_ADDR, 8'h02);
		for (n = 0; n < 60 && pin_oe !== 1'b1; n++)
			@(posedge clk);
		check(n, 60);
		wr(SYNC_CONTROL_ADDR, 8'h05);
		meas(8'h04, a);
		meas(8'h09, b);
		meas(8'h14, c);
		check(b - a, 10);
		check(c, a);
		rd(MODULATOR_PHASE_DELAY_ADDR, 8'h14);
		meas(8'h10, c);
		meas(8'h00, b);
		check(c, b);
		wait_cyc(3);
		wrap_up();
	end
endmodule : amp_status_error_regs_bench
